/* ddrgb_monitor.sv */
/*
  Port checker for ddrgb_top: APB answer timing, error replies, reset state of the pads
  and spacing of the fabric enable pulse.
  Assumes it is attached by the bind below and sees the ports of ddrgb_top only.
*/
`timescale 1ns/10ps
module ddrgb_monitor #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // APB answer side.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  // Stream and pads.
  input wire logic FABRIC_EN,
  input wire logic NBR_CELL_BUSY,
  input wire logic [WIDTH-1:0] PAD_OUT,
  input wire logic [WIDTH-1:0] PAD_OE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // An access phase that has not yet been answered.
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  // Start of a four-slot gearbox word.
  sequence s_word2x;
    FABRIC_EN && NBR_CELL_BUSY;
  endsequence
  // A gearbox word start with 2x still in force four slots later.
  sequence s_word2x_held;
    s_word2x ##4 NBR_CELL_BUSY;
  endsequence
  a_one_wait: assert property (s_wait |=> PREADY) else $error("ready came late");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_ready_cause: assert property (!PSEL |=> !PREADY) else $error("ready without access");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error outside answer");
  a_err_nodata: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("error with data");
  a_reset_low: assert property ($fell(RST) |-> PAD_OUT == '0 && PAD_OE == '0 && !FABRIC_EN)
    else $error("pads not quiet after reset");
  a_fabric_pulse: assert property (FABRIC_EN |=> !FABRIC_EN)
    else $error("fabric enable held");
  a_gear_period: assert property (s_word2x |=> !FABRIC_EN [*3])
    else $error("gearbox word shorter than four slots");
  a_gear_next: assert property (s_word2x_held |-> FABRIC_EN)
    else $error("gearbox word longer than four slots");
endmodule
bind ddrgb_top ddrgb_monitor #(.WIDTH(WIDTH)) u_ddrgb_monitor (.SYS_CLK, .RST, .PSEL,
  .PENABLE, .PREADY, .PSLVERR, .PRDATA, .FABRIC_EN, .NBR_CELL_BUSY, .PAD_OUT, .PAD_OE);

/* ddrgb_pad_model.sv */
/*
  Device beyond the pads: puts its own changing pattern on every line the block leaves free.
  Assumes one pad line per bit and the common system clock.
*/
`timescale 1ns/10ps
module ddrgb_pad_model #(
  parameter int WIDTH = 8
) (
  // Clock.
  input wire logic clk,
  // Pad lines.
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pad_in
);
  logic [WIDTH-1:0] drive_ff = '0;
  // A new value every cycle, so a wrong delay tap cannot pass by chance.
  always @(posedge clk) begin
    drive_ff <= WIDTH'($urandom);
  end
  // The block wins on lines it drives; the device holds the rest.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drive_ff);
endmodule

/* ddrgb_pkg.sv */
/*
  Package for the DDR output gearbox and input delay block: register map, control field
  positions, reset values, enumerations and timing constants.
  Assumes a 32-bit APB register bus and one system clock of 50 MHz.
*/
package ddrgb_pkg;

  // Register byte addresses.
  localparam logic [11:0] DDRGB_CTRL_ADDR = 12'h000;
  localparam logic [11:0] DDRGB_STATUS_ADDR = 12'h004;

  // Control register field positions.
  localparam int DDRGB_CTRL_EN_BIT = 0;
  localparam int DDRGB_CTRL_MODE_LSB = 1;
  localparam int DDRGB_CTRL_GEAR_BIT = 3;
  localparam int DDRGB_CTRL_DLYM_LSB = 4;
  localparam int DDRGB_CTRL_MULT_LSB = 6;
  localparam int DDRGB_CTRL_SCLK_BIT = 10;
  localparam int DDRGB_CTRL_WIDTH = 11;
  localparam logic [10:0] DDRGB_CTRL_RESET = 11'h000;

  // Status register field positions.
  localparam int DDRGB_STAT_CODE_LSB = 0;
  localparam int DDRGB_STAT_SLOT_LSB = 4;
  localparam int DDRGB_STAT_GEAR_BIT = 8;
  localparam int DDRGB_STAT_OE_BIT = 9;

  // Block modes.
  typedef enum logic [1:0] {
    DDRGB_MODE_INPUT = 2'h0,
    DDRGB_MODE_OUTPUT = 2'h1,
    DDRGB_MODE_BIDIR = 2'h2,
    DDRGB_MODE_TRISTATE = 2'h3
  } ddrgb_mode_type;

  // Input delay modes.
  typedef enum logic [1:0] {
    DDRGB_DLY_DYNAMIC = 2'h0,
    DDRGB_DLY_FIXED = 2'h1,
    DDRGB_DLY_PRESET = 2'h2
  } ddrgb_dly_type;

  // Serializer slots, one per edge-clock half period, written one-hot.
  typedef enum logic [3:0] {
    DDRGB_SLOT0 = 4'h1,
    DDRGB_SLOT1 = 4'h2,
    DDRGB_SLOT2 = 4'h4,
    DDRGB_SLOT3 = 4'h8
  } ddrgb_slot_type;

  // Delay line figures.
  localparam int DDRGB_CODE_BITS = 4;
  localparam int DDRGB_TAPS = 16;
  localparam int DDRGB_STEP_PS = 35;
  localparam logic [3:0] DDRGB_MULT_RESET = 4'h0;

  // Timing: one system clock period stands for one edge-clock half period.
  localparam int DDRGB_SYS_CLK_MHZ = 50;
  localparam int DDRGB_SYS_PERIOD_PS = 1000000 / DDRGB_SYS_CLK_MHZ;
  localparam int DDRGB_SLOTS_1X = 2;
  localparam int DDRGB_SLOTS_2X = 4;

endpackage

/* ddrgb_top.sv */
/*
  DDR output serializer (1x), output gearbox (2x), tristate DDR register and a 16-tap input
  delay element, configured and observed over APB.
  Assumes all inputs are synchronous to SYS_CLK; each SYS_CLK cycle is one half period of
  the modelled edge clock, and FABRIC_EN marks the slow fabric clock as an enable pulse.
*/
`timescale 1ns/10ps
module ddrgb_top import ddrgb_pkg::*; #(
  parameter int WIDTH = 8,
  parameter logic [3:0] PRESET_CODE = 4'h8
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Fabric side data for the serializer and gearbox.
  input wire logic [WIDTH-1:0] NEG_PHASE_DATA_A,
  input wire logic [WIDTH-1:0] POS_PHASE_DATA_A,
  input wire logic [WIDTH-1:0] NEG_PHASE_DATA_B,
  input wire logic [WIDTH-1:0] POS_PHASE_DATA_B,
  input wire logic [WIDTH-1:0] NEG_PHASE_TS_IN,
  input wire logic [WIDTH-1:0] POS_PHASE_TS_IN,
  input wire logic [3:0] DELAY_CODE,
  output logic FABRIC_EN,
  output logic NBR_CELL_BUSY,
  // Pad side.
  output logic [WIDTH-1:0] PAD_OUT,
  output logic [WIDTH-1:0] PAD_OE,
  input wire logic [WIDTH-1:0] PAD_IN,
  output logic [WIDTH-1:0] DELAYED_DATA
);

  // Resolves the delay code that the delay line uses. Fixed and preset modes ignore the
  // dynamic input entirely, so fabric logic need not drive it with anything meaningful.
  function automatic logic [3:0] eff_code(input logic [1:0] dm, input logic [3:0] mult,
                                          input logic [3:0] dyn);
    logic [3:0] c;
    c = dyn;
    if (dm == DDRGB_DLY_FIXED) begin
      c = mult;
    end else if (dm == DDRGB_DLY_PRESET) begin
      c = PRESET_CODE;
    end
    return c;
  endfunction

  // Register state; every name ending in _ff is a flip-flop, nxt_ names its next value.
  logic [10:0] ctrl_ff, nxt_ctrl;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  ddrgb_slot_type slot_ff, nxt_slot;
  logic fab_en_ff, nxt_fab_en;
  logic busy_ff, nxt_busy;
  logic [WIDTH-1:0] stage_ff [4];
  logic [WIDTH-1:0] nxt_stage [4];
  logic [WIDTH-1:0] word_ff [4];
  logic [WIDTH-1:0] nxt_word [4];
  logic [WIDTH-1:0] ts_stage_ff [2];
  logic [WIDTH-1:0] nxt_ts_stage [2];
  logic [WIDTH-1:0] ts_word_ff [2];
  logic [WIDTH-1:0] nxt_ts_word [2];
  logic [WIDTH-1:0] pad_ff, nxt_pad;
  logic [WIDTH-1:0] oe_ff, nxt_oe;
  logic [WIDTH-1:0] taps_ff [DDRGB_TAPS];
  logic [WIDTH-1:0] nxt_taps [DDRGB_TAPS];
  logic [WIDTH-1:0] dly_ff, nxt_dly;

  // Decodes of the control word, shared by the processes below.
  logic enable;
  ddrgb_mode_type mode;
  logic gear2x;
  logic single_clk;
  logic [3:0] code;
  logic last_slot;
  logic delay_on;

  // Decoded control fields; 2x is refused outside input and output modes.
  assign enable = ctrl_ff[DDRGB_CTRL_EN_BIT];
  assign mode = ddrgb_mode_type'(ctrl_ff[DDRGB_CTRL_MODE_LSB +: 2]);
  assign gear2x = ctrl_ff[DDRGB_CTRL_GEAR_BIT] && (mode == DDRGB_MODE_INPUT ||
                  mode == DDRGB_MODE_OUTPUT);
  assign single_clk = ctrl_ff[DDRGB_CTRL_SCLK_BIT] && !gear2x;
  assign code = eff_code(ctrl_ff[DDRGB_CTRL_DLYM_LSB +: 2],
                         ctrl_ff[DDRGB_CTRL_MULT_LSB +: 4], DELAY_CODE);
  assign delay_on = (mode == DDRGB_MODE_INPUT || mode == DDRGB_MODE_BIDIR);
  assign last_slot = gear2x ? (slot_ff == DDRGB_SLOT3) : (slot_ff == DDRGB_SLOT1);

  // APB slave: one wait state, unmapped addresses answer with an error and zero data.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (PSEL && PENABLE && !pready_ff) begin
      nxt_pready = 1'b1;
      nxt_prdata = 32'h0000_0000;
      if (PADDR == DDRGB_CTRL_ADDR) begin
        if (!PWRITE) begin
          nxt_prdata[DDRGB_CTRL_WIDTH-1:0] = ctrl_ff;
        end
      end else if (PADDR == DDRGB_STATUS_ADDR) begin
        if (!PWRITE) begin
          nxt_prdata[DDRGB_STAT_CODE_LSB +: 4] = code;
          nxt_prdata[DDRGB_STAT_SLOT_LSB +: 4] = slot_ff;
          nxt_prdata[DDRGB_STAT_GEAR_BIT] = gear2x;
          nxt_prdata[DDRGB_STAT_OE_BIT] = |oe_ff;
        end
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
    // A write lands on the edge that ends the transfer, where the master sees ready; taking
    // it one edge earlier would act before the slave had answered.
    if (PSEL && PENABLE && pready_ff && PWRITE && (PADDR == DDRGB_CTRL_ADDR)) begin
      nxt_ctrl = PWDATA[DDRGB_CTRL_WIDTH-1:0];
    end
  end

  // Register bus state. Read data keeps its last value between replies; the master takes
  // it only in the cycle in which ready stands.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_ff <= DDRGB_CTRL_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Slot sequencer: the slow fabric enable is one pulse per full word, so in 2x the fabric
  // rate is exactly half the edge-clock rate and locked to it.
  // A disabled block parks in the first slot, so every start puts slot 1, a positive phase, on the pad first.
  always_comb begin
    nxt_slot = DDRGB_SLOT0;
    if (enable) begin
      case (slot_ff)
        DDRGB_SLOT0: nxt_slot = DDRGB_SLOT1;
        DDRGB_SLOT1: nxt_slot = gear2x ? DDRGB_SLOT2 : DDRGB_SLOT0;
        DDRGB_SLOT2: nxt_slot = DDRGB_SLOT3;
        DDRGB_SLOT3: nxt_slot = DDRGB_SLOT0;
        default: nxt_slot = DDRGB_SLOT0;
      endcase
    end
    nxt_fab_en = enable && (gear2x ? (nxt_slot == DDRGB_SLOT3) :
                 (nxt_slot == DDRGB_SLOT1));
    // The neighbour cell's registers are claimed only while 2x is really in force.
    nxt_busy = gear2x;
  end

  // Word capture. With separate clocks the fabric word first lands in a transfer stage;
  // the single-clock option skips it and saves one word of latency.
  always_comb begin
    nxt_stage = stage_ff;
    nxt_word = word_ff;
    nxt_ts_stage = ts_stage_ff;
    nxt_ts_word = ts_word_ff;
    if (enable && last_slot) begin
      nxt_stage[0] = NEG_PHASE_DATA_A;
      nxt_stage[1] = POS_PHASE_DATA_A;
      nxt_stage[2] = NEG_PHASE_DATA_B;
      nxt_stage[3] = POS_PHASE_DATA_B;
      // Drive enables take the same path as the data so both stay on the same slot.
      nxt_ts_stage[0] = NEG_PHASE_TS_IN;
      nxt_ts_stage[1] = POS_PHASE_TS_IN;
      if (single_clk) begin
        nxt_word[0] = NEG_PHASE_DATA_A;
        nxt_word[1] = POS_PHASE_DATA_A;
        nxt_ts_word[0] = NEG_PHASE_TS_IN;
        nxt_ts_word[1] = POS_PHASE_TS_IN;
      end else begin
        nxt_word[0] = stage_ff[0];
        nxt_word[1] = stage_ff[1];
        nxt_ts_word[0] = ts_stage_ff[0];
        nxt_ts_word[1] = ts_stage_ff[1];
      end
      // Upper half of the word lives in the paired cell's registers.
      nxt_word[2] = stage_ff[2];
      nxt_word[3] = stage_ff[3];
    end
  end

  // Pad mux, advanced on every edge-clock half period so the stream follows that clock.
  always_comb begin
    nxt_pad = '0;
    nxt_oe = '0;
    if (enable) begin
      case (nxt_slot)
        DDRGB_SLOT0: nxt_pad = nxt_word[0];
        DDRGB_SLOT1: nxt_pad = nxt_word[1];
        DDRGB_SLOT2: nxt_pad = nxt_word[2];
        DDRGB_SLOT3: nxt_pad = nxt_word[3];
        default: nxt_pad = '0;
      endcase
      case (mode)
        DDRGB_MODE_OUTPUT: nxt_oe = '1;
        DDRGB_MODE_BIDIR, DDRGB_MODE_TRISTATE: begin
          nxt_oe = (nxt_slot == DDRGB_SLOT1) ? nxt_ts_word[1] : nxt_ts_word[0];
        end
        default: nxt_oe = '0;
      endcase
      // Input mode keeps the pad data low so no stale word reaches a receiving pin.
      if (mode == DDRGB_MODE_INPUT) begin
        nxt_pad = '0;
      end
    end
  end

  // Reset empties every stage, so the pad stays low until the first word after release.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      slot_ff <= DDRGB_SLOT0;
      fab_en_ff <= 1'b0;
      busy_ff <= 1'b0;
      stage_ff <= '{default: '0};
      word_ff <= '{default: '0};
      ts_stage_ff <= '{default: '0};
      ts_word_ff <= '{default: '0};
      pad_ff <= '0;
      oe_ff <= '0;
    end else begin
      slot_ff <= nxt_slot;
      fab_en_ff <= nxt_fab_en;
      busy_ff <= nxt_busy;
      stage_ff <= nxt_stage;
      word_ff <= nxt_word;
      ts_stage_ff <= nxt_ts_stage;
      ts_word_ff <= nxt_ts_word;
      pad_ff <= nxt_pad;
      oe_ff <= nxt_oe;
    end
  end

  // Input delay line: tap k stands for k steps of the fine delay, scaled to whole cycles
  // here since a 35 ps step is far below one system clock period.
  // A code change takes effect at once, so a word in flight may see a bit twice or lose one.
  always_comb begin
    nxt_taps[0] = PAD_IN;
    for (int k = 1; k < DDRGB_TAPS; k++) begin
      nxt_taps[k] = taps_ff[k-1];
    end
    nxt_dly = '0;
    if (delay_on) begin
      nxt_dly = (code == 4'h0) ? PAD_IN : taps_ff[code - 4'h1];
    end
  end

  // The taps clear on reset, so delayed data reads low until the line has refilled.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      taps_ff <= '{default: '0};
      dly_ff <= '0;
    end else begin
      taps_ff <= nxt_taps;
      dly_ff <= nxt_dly;
    end
  end

  // Outputs come straight from flip-flops.
  // No output passes through logic after its register, so pad timing is set by the clock.
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign FABRIC_EN = fab_en_ff;
  assign NBR_CELL_BUSY = busy_ff;
  assign PAD_OUT = pad_ff;
  assign PAD_OE = oe_ff;
  assign DELAYED_DATA = dly_ff;

endmodule

/* ddrgb_top_tb.sv */
/*
  Self-checking bench for ddrgb_top: registers over APB, 1x and 2x streams, tristate
  control and the input delay line.
  Assumes ddrgb_pad_model on the pads and the bound port checker.
*/
`timescale 1ns/10ps
module ddrgb_top_tb import ddrgb_pkg::*; ;
  localparam int W = 8;
  localparam logic [3:0] PRE = 4'h5;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold_b = 1'b0;
  logic pready, pslverr, fabric_en, nbr, err, two;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [W-1:0] na = '0, pa = '0, nb = '0, pb = '0, nt = '0, pt = '0;
  logic [W-1:0] pad_out, pad_oe, pad_in, dly;
  logic [W-1:0] hist [0:16];
  logic [3:0] code = 4'h0, mult, exp_code;
  logic [1:0] md [5] = '{DDRGB_MODE_OUTPUT, DDRGB_MODE_OUTPUT, DDRGB_MODE_OUTPUT,
    DDRGB_MODE_TRISTATE, DDRGB_MODE_BIDIR};
  bit [4:0] gr = 5'b10100, sc = 5'b11001;
  int failures = 0, num_checks = 0, cycles = 0;
  ddrgb_top #(.WIDTH(W), .PRESET_CODE(PRE)) u_ddrgb_top (.SYS_CLK(clk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NEG_PHASE_DATA_A(na),
    .POS_PHASE_DATA_A(pa), .NEG_PHASE_DATA_B(nb), .POS_PHASE_DATA_B(pb),
    .NEG_PHASE_TS_IN(nt), .POS_PHASE_TS_IN(pt), .DELAY_CODE(code), .FABRIC_EN(fabric_en),
    .NBR_CELL_BUSY(nbr), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_IN(pad_in),
    .DELAYED_DATA(dly));
  ddrgb_pad_model #(.WIDTH(W)) u_ddrgb_pad_model (.clk(clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_in(pad_in));
  // Clock of 50 MHz.
  always #10 clk = ~clk;
  // Fresh fabric words each cycle; the B pair can be held so its word lag does not matter.
  always @(posedge clk) begin
    na <= W'($urandom);
    pa <= W'($urandom);
    nt <= W'($urandom);
    pt <= W'($urandom);
    if (!hold_b) begin
      nb <= W'($urandom);
      pb <= W'($urandom);
    end
    for (int i = 16; i > 0; i--) hist[i] <= hist[i-1];
    hist[0] <= pad_in;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      finish_test();
    end
  end
  // Expected drive enables for a slot.
  function automatic logic [W-1:0] exp_oe(logic [1:0] m, logic [W-1:0] ts);
    return (m == DDRGB_MODE_OUTPUT) ? '1 : (m == DDRGB_MODE_INPUT) ? '0 : ts;
  endfunction
  // Control word: enable set, then mode, gear, delay mode, multiplier, single clock.
  function automatic logic [31:0] ctrl(logic [1:0] m, bit g, logic [1:0] dm,
    logic [3:0] mu, bit s);
    return {21'h0, s, mu, dm, g, m, 1'b1};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until ready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Catches three words and follows each through its slots on the pad.
  task automatic stream(input int lat, input logic [1:0] m);
    logic [W-1:0] s [4];
    logic [W-1:0] t [2];
    int n;
    for (int w = 0; w < 3; w++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (fabric_en !== 1'b1 && n < 40);
      s = '{na, pa, nb, pb};
      t = '{nt, pt};
      repeat (lat + 1) @(negedge clk);
      for (int k = 0; k < (two ? 4 : 2); k++) begin
        check(pad_out, s[k]);
        check(pad_oe, exp_oe(m, t[k % 2]));
        @(negedge clk);
      end
    end
  endtask
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n - 1) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(pad_out | pad_oe, 0);
    apb(1'b0, DDRGB_CTRL_ADDR, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    void'($urandom(71));
    do_reset(10);
    apb(1'b0, 12'h0f0, 32'h0);
    check({rd[0], err}, 2'b01);
    apb(1'b1, DDRGB_STATUS_ADDR, 32'hffff_ffff);
    check(err, 1'b0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, DDRGB_CTRL_ADDR, 32'h0);
      hold_b <= (i == 2);
      two = gr[i] && md[i] == DDRGB_MODE_OUTPUT;
      apb(1'b1, DDRGB_CTRL_ADDR, ctrl(md[i], gr[i], DDRGB_DLY_DYNAMIC, 4'h0, sc[i]));
      apb(1'b0, DDRGB_STATUS_ADDR, 32'h0);
      check(rd[DDRGB_STAT_GEAR_BIT], two);
      check(nbr, two);
      stream(sc[i] ? 0 : (two ? 4 : 2), md[i]);
    end
    for (int i = 0; i < 4; i++) begin
      mult = 4'($urandom);
      apb(1'b1, DDRGB_CTRL_ADDR, ctrl(DDRGB_MODE_INPUT, 1'b0, (i == 3) ? DDRGB_DLY_PRESET :
        (i == 2) ? DDRGB_DLY_FIXED : DDRGB_DLY_DYNAMIC, mult, 1'b1));
      code <= (i == 0) ? 4'h0 : (i == 1) ? 4'hf : ~mult;
      apb(1'b0, DDRGB_STATUS_ADDR, 32'h0);
      repeat (20) @(negedge clk);
      exp_code = (i == 3) ? PRE : (i == 2) ? mult : code;
      check(dly, hist[exp_code]);
      check(rd[3:0], exp_code);
      check(pad_out | pad_oe, 0);
    end
    apb(1'b1, DDRGB_CTRL_ADDR, ctrl(DDRGB_MODE_OUTPUT, 1'b0, DDRGB_DLY_DYNAMIC, 4'h0, 1'b1));
    repeat (20) @(negedge clk);
    check(dly, 0);
    do_reset(2);
    finish_test();
  end
endmodule
